// ### trm_pkg.sv
// Purpose: Shared constants and carriers for the sensor trim register bank
// Assumes: Serial framing is decoded elsewhere into byte-wide register requests
// Notes:   Offsets are the byte pointers used on the serial link
package trm_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_GAIN_COARSE_LOW  = 8'h51;
    localparam logic [7:0] ADDR_GAIN_COARSE_HIGH = 8'h52;
    localparam logic [7:0] ADDR_GAIN_FINE_LOW    = 8'h54;
    localparam logic [7:0] ADDR_DRIFT_POLARITY   = 8'h55;
    localparam logic [7:0] ADDR_REFERENCE_FINE   = 8'h57;
    localparam logic [7:0] ADDR_BW_GAIN_FINE_HI  = 8'h5a;

    // ==========================================================
    // Reset values and read answer for an unmapped pointer
    localparam logic [7:0] RESET_TRIM_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // ==========================================================
    // Field positions
    localparam int DRIFT_SIGN_BIT = 6;
    localparam int DRIFT_MAG_HI   = 5;
    localparam int DRIFT_MAG_LO   = 1;
    localparam int POLARITY_BIT   = 0;
    localparam int REF_CODE_HI    = 5;
    localparam int COARSE_LOW_HI  = 4;
    localparam int COARSE_HI_BIT  = 0;
    localparam int FINE_UPPER_HI  = 1;
    localparam int BW_SEL_HI      = 7;
    localparam int BW_SEL_LO      = 6;

    // ==========================================================
    // Coarse range codes, {low byte bits 4..0, high byte bit 0}
    localparam logic [5:0] COARSE_RANGE_1 = 6'h00;
    localparam logic [5:0] COARSE_RANGE_2 = 6'h01;
    localparam logic [5:0] COARSE_RANGE_3 = 6'h09;
    localparam logic [5:0] COARSE_RANGE_4 = 6'h0d;
    localparam logic [5:0] COARSE_RANGE_5 = 6'h0f;
    localparam logic [5:0] COARSE_RANGE_6 = 6'h2f;
    localparam logic [5:0] COARSE_RANGE_7 = 6'h3f;

    // ==========================================================
    // Fine gain law, Q16: scale = (1823 + c - code) / (1823 + c), c = 2.14714
    localparam logic [31:0] GAIN_BASE      = 32'h0000_071f;
    localparam logic [31:0] GAIN_C_Q16     = 32'h0002_25ab;
    localparam int          GAIN_FRAC_BITS = 16;
    localparam logic [31:0] GAIN_NUM_Q16   = (GAIN_BASE << GAIN_FRAC_BITS) + GAIN_C_Q16;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } trm_req_s;

    typedef struct packed {
        logic        driftPositive;
        logic [4:0]  driftMagnitude;
        logic        polaritySelect;
        logic [5:0]  refCode;
        logic [5:0]  coarseCode;
        logic [2:0]  coarseRange;
        logic [9:0]  fineCode;
        logic [1:0]  bandwidthSelect;
        logic [31:0] gainScale;
    } trm_trim_s;

endpackage

// ### trm_byte_reg.sv
// Purpose: One trim byte, loaded whole on a write strobe
// Assumes: Strobe and data are synchronous to clk
// Notes:   Reset value is a parameter
module trm_byte_reg #(
    parameter int         WIDTH     = 8,
    parameter logic [7:0] RESET_VAL = trm_pkg::RESET_TRIM_BYTE
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] dataIn,
    output      logic [WIDTH-1:0] dataOut
);

    if (WIDTH != 8) begin : g_width_check
        $error("trm_byte_reg serves byte-wide registers only");
    end

    logic [WIDTH-1:0] data_reg;
    logic [WIDTH-1:0] data_next;

    // ==========================================================
    // Whole-byte update
    always_comb begin
        data_next = data_reg;
        if (load) begin
            data_next = dataIn;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_reg <= RESET_VAL;
        end else begin
            data_reg <= data_next;
        end
    end

    assign dataOut = data_reg;

endmodule

// ### trm_register_bank.sv
// Purpose: Trim register bank of a linear magnetic sensor
// Assumes: Link logic hands over one decoded byte request per cycle
// Notes:   Decoded trim values are registered one cycle behind the bytes
//
// What this block does
// - Drift byte: bit 7 zero, bits 6..1 drift trim setting, bit 0 polarity.
// - Drift trim is sign-magnitude: bits 5..1 magnitude, bit 6 one is positive.
// - Reference fine trim bits 5..0 form an unsigned code 0 to 63.
// - Reference fine trim byte can be read back as well as written.
// - Coarse code is first coarse bits 4..0 with second coarse bit 0.
// - Coarse codes in the table decode to ranges 1 to 7, gain x2 down to /32; other codes give range 0.
// - Fine code is upper byte bits 1..0 above lower byte bits 7..0.
// - Fine gain code is unsigned, 0 to 1023.
// - Bandwidth select sits in upper fine byte bits 7 and 6.
// - Gain scales by (1823 + c - fine) / (1823 + c), c 2.14714; the gainScale output holds only the Q16 numerator.
module trm_register_bank (
    input  wire logic                clk,
    input  wire logic                arst_n,
    input  wire trm_pkg::trm_req_s   req,
    output      logic [7:0]          rdData,
    output      logic                rdValid,
    output      trm_pkg::trm_trim_s  trim
);

    // ==========================================================
    // Byte storage
    localparam int NUM_BYTES = 6;
    localparam logic [7:0] BYTE_ADDR [NUM_BYTES] = '{
        trm_pkg::ADDR_GAIN_COARSE_LOW, trm_pkg::ADDR_GAIN_COARSE_HIGH,
        trm_pkg::ADDR_GAIN_FINE_LOW,   trm_pkg::ADDR_DRIFT_POLARITY,
        trm_pkg::ADDR_REFERENCE_FINE,  trm_pkg::ADDR_BW_GAIN_FINE_HI};

    logic [7:0] bytes [NUM_BYTES];
    logic [7:0] coarseLow;
    logic [7:0] coarseHigh;
    logic [7:0] fineLow;
    logic [7:0] driftByte;
    logic [7:0] refByte;
    logic [7:0] fineHigh;

    // Stored as written; reserved bits are the controller's to keep clean
    for (genvar i = 0; i < NUM_BYTES; i++) begin : g_bytes
        trm_byte_reg #(
            .WIDTH     (8),
            .RESET_VAL (trm_pkg::RESET_TRIM_BYTE)
        ) u_byte (
            .clk     (clk),
            .arst_n  (arst_n),
            .load    (req.wr && (req.addr == BYTE_ADDR[i])),
            .dataIn  (req.data),
            .dataOut (bytes[i])
        );
    end

    assign coarseLow  = bytes[0];
    assign coarseHigh = bytes[1];
    assign fineLow    = bytes[2];
    assign driftByte  = bytes[3];
    assign refByte    = bytes[4];
    assign fineHigh   = bytes[5];

    // ==========================================================
    // Read port
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic       rdValid_reg;
    logic       rdValid_next;

    always_comb begin
        rdValid_next = req.rd;
        rdData_next  = rdData_reg;
        if (req.rd) begin
            rdData_next = trm_pkg::UNMAPPED_READ;
            for (int i = 0; i < NUM_BYTES; i++) begin
                if (req.addr == BYTE_ADDR[i]) begin
                    rdData_next = bytes[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_reg  <= trm_pkg::UNMAPPED_READ;
            rdValid_reg <= 1'b0;
        end else begin
            rdData_reg  <= rdData_next;
            rdValid_reg <= rdValid_next;
        end
    end

    assign rdData  = rdData_reg;
    assign rdValid = rdValid_reg;

    // ==========================================================
    // Decoded trim values
    trm_pkg::trm_trim_s trim_reg;
    trm_pkg::trm_trim_s trim_next;

    always_comb begin
        trim_next.driftPositive   = driftByte[trm_pkg::DRIFT_SIGN_BIT];
        trim_next.driftMagnitude  =
            driftByte[trm_pkg::DRIFT_MAG_HI:trm_pkg::DRIFT_MAG_LO];
        trim_next.polaritySelect  = driftByte[trm_pkg::POLARITY_BIT];
        trim_next.refCode         = refByte[trm_pkg::REF_CODE_HI:0];
        trim_next.coarseCode      =
            {coarseLow[trm_pkg::COARSE_LOW_HI:0], coarseHigh[trm_pkg::COARSE_HI_BIT]};
        trim_next.fineCode        = {fineHigh[trm_pkg::FINE_UPPER_HI:0], fineLow};
        trim_next.bandwidthSelect = fineHigh[trm_pkg::BW_SEL_HI:trm_pkg::BW_SEL_LO];
        // Scale kept as a Q16 numerator; the divide by 1823 + c is left to the user
        trim_next.gainScale = trm_pkg::GAIN_NUM_Q16
            - ({22'h000000, trim_next.fineCode} << trm_pkg::GAIN_FRAC_BITS);
        // Codes outside the table give range 0 so software can spot them
        case (trim_next.coarseCode)
            trm_pkg::COARSE_RANGE_1: trim_next.coarseRange = 3'h1;
            trm_pkg::COARSE_RANGE_2: trim_next.coarseRange = 3'h2;
            trm_pkg::COARSE_RANGE_3: trim_next.coarseRange = 3'h3;
            trm_pkg::COARSE_RANGE_4: trim_next.coarseRange = 3'h4;
            trm_pkg::COARSE_RANGE_5: trim_next.coarseRange = 3'h5;
            trm_pkg::COARSE_RANGE_6: trim_next.coarseRange = 3'h6;
            trm_pkg::COARSE_RANGE_7: trim_next.coarseRange = 3'h7;
            default:                 trim_next.coarseRange = 3'h0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_reg <= '{default: '0, gainScale: trm_pkg::GAIN_NUM_Q16, coarseRange: 3'h1};
        end else begin
            trim_reg <= trim_next;
        end
    end

    assign trim = trim_reg;

    // ==========================================================
    // Checks
    logic wrDrift;
    logic wrRef;
    logic wrFineLow;
    logic rdRef;

    assign wrDrift   = req.wr && (req.addr == trm_pkg::ADDR_DRIFT_POLARITY);
    assign wrRef     = req.wr && (req.addr == trm_pkg::ADDR_REFERENCE_FINE);
    assign wrFineLow = req.wr && (req.addr == trm_pkg::ADDR_GAIN_FINE_LOW);
    assign rdRef     = req.rd && (req.addr == trm_pkg::ADDR_REFERENCE_FINE);

    a_drift_fields: assert property (@(posedge clk) disable iff (!arst_n)
        wrDrift |-> ##2 ((trim.polaritySelect == $past(req.data[0], 2))
            && (trim.driftPositive == $past(req.data[6], 2))))
        else $error("drift byte fields not decoded");

    a_drift_magnitude: assert property (@(posedge clk) disable iff (!arst_n)
        wrDrift |-> ##2 (trim.driftMagnitude == $past(req.data[5:1], 2)))
        else $error("drift magnitude not decoded");

    a_ref_code: assert property (@(posedge clk) disable iff (!arst_n)
        wrRef |-> ##2 (trim.refCode == $past(req.data[5:0], 2)))
        else $error("reference code not decoded");

    a_ref_readback: assert property (@(posedge clk) disable iff (!arst_n)
        wrRef ##1 rdRef |=> rdValid && (rdData == $past(req.data, 2)))
        else $error("reference byte did not read back");

    a_coarse_join: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(coarseLow[0]) |=> trim.coarseCode[1])
        else $error("coarse code bit placement wrong");

    a_range_decode: assert property (@(posedge clk) disable iff (!arst_n)
        (trim.coarseRange == 3'h4) |-> (trim.coarseCode == 6'h0d))
        else $error("coarse range decode wrong");

    a_fine_code: assert property (@(posedge clk) disable iff (!arst_n)
        wrFineLow |-> ##2 (trim.fineCode[7:0] == $past(req.data, 2)))
        else $error("fine code lower bits wrong");

    a_bw_field: assert property (@(posedge clk) disable iff (!arst_n)
        $changed(fineHigh) |=> (trim.bandwidthSelect == $past(fineHigh[7:6])))
        else $error("bandwidth select misplaced");

    a_gain_scale: assert property (@(posedge clk) disable iff (!arst_n)
        (trim.fineCode == 10'h000) |-> (trim.gainScale == trm_pkg::GAIN_NUM_Q16))
        else $error("gain scale not peak at code zero");

    a_read_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        !req.rd |=> !rdValid)
        else $error("read valid without request");

endmodule

// ### trm_ctrl_model.sv
// Purpose: Controller model issuing byte requests to the trim bank
// Assumes: One request per call of op, two back to back in op_pair, then one idle cycle
// Notes:   Fine gain update is read-modify-write of the upper byte
module trm_ctrl_model (
    input  wire logic              clk,
    input  wire logic [7:0]        rdData,
    input  wire logic              rdValid,
    output      trm_pkg::trm_req_s req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // ==========================================================
    // Requests
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: r, addr: a, data: d};
        @(posedge clk);
        req <= '0;
    endtask
    // Two requests on consecutive edges, with no idle cycle between them
    task automatic op_pair(input trm_pkg::trm_req_s first, input trm_pkg::trm_req_s second);
        @(posedge clk);
        req <= first;
        @(posedge clk);
        req <= second;
        @(posedge clk);
        req <= '0;
    endtask
    // Upper byte is shared, so its other bits are read first and resent
    task automatic set_fine(input logic [9:0] code);
        logic [7:0] keep;
        keep = 8'h00;
        op(1'b0, 1'b1, trm_pkg::ADDR_BW_GAIN_FINE_HI, 8'h00);
        @(posedge clk);
        if (rdValid === 1'b1) keep = rdData;
        op(1'b1, 1'b0, trm_pkg::ADDR_BW_GAIN_FINE_HI, {keep[7:2], code[9:8]});
        op(1'b1, 1'b0, trm_pkg::ADDR_GAIN_FINE_LOW, code[7:0]);
    endtask
endmodule

// ### sensor_trim_register_bank_tb.sv
// Purpose: Self-checking bench of the trim register bank
// Assumes: Read answer one cycle after the request
// Notes:   Expected bytes come from a shadow copy kept by the bench
module sensor_trim_register_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ADDRS [6] = '{8'h51, 8'h52, 8'h54, 8'h55, 8'h57, 8'h5a};
    localparam logic [5:0] RANGE_CODE [7] = '{6'h00, 6'h01, 6'h09, 6'h0d, 6'h0f, 6'h2f, 6'h3f};
    logic               clk;
    logic               arst_n;
    trm_pkg::trm_req_s  req;
    logic [7:0]         rdData;
    logic               rdValid;
    trm_pkg::trm_trim_s trim;
    logic [7:0]         shadow [logic [7:0]];
    logic [7:0]         expQ [$];
    logic [7:0]         lfsr;
    int                 n_errors;
    int                 check_count;

    trm_register_bank i_dut (.clk(clk), .arst_n(arst_n), .req(req), .rdData(rdData),
                             .rdValid(rdValid), .trim(trim));
    trm_ctrl_model i_ctrl (.clk(clk), .rdData(rdData), .rdValid(rdValid), .req(req));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ==========================================================
    // Models
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] sh(input logic [7:0] a);
        return shadow.exists(a) ? shadow[a] : 8'h00;
    endfunction
    function automatic trm_pkg::trm_trim_s exp_trim();
        trm_pkg::trm_trim_s t;
        logic [7:0] b55 = sh(8'h55);
        logic [7:0] b5a = sh(8'h5a);
        logic [7:0] b51 = sh(8'h51);
        logic [7:0] b52 = sh(8'h52);
        t = '0;
        t.driftPositive = b55[6];
        t.driftMagnitude = b55[5:1];
        t.polaritySelect = b55[0];
        t.refCode = 6'(sh(8'h57));
        t.coarseCode = {b51[4:0], b52[0]};
        for (int i = 0; i < 7; i++) if (t.coarseCode == RANGE_CODE[i]) t.coarseRange = 3'(i + 1);
        t.fineCode = {b5a[1:0], sh(8'h54)};
        t.bandwidthSelect = b5a[7:6];
        t.gainScale = trm_pkg::GAIN_NUM_Q16 - {6'h00, t.fineCode, 16'h0000};
        return t;
    endfunction

    // ==========================================================
    // Checks and requests
    task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected rdData: expected %h, seen %h", e, s);
        end
    endtask
    task automatic cmp_trim(input trm_pkg::trm_trim_s e);
        // Decoded values trail the byte by one edge
        @(posedge clk);
        @(negedge clk);
        check_count++;
        if (trim !== e) begin
            n_errors++;
            $display("unexpected trim: expected %h, seen %h", e, trim);
        end
    endtask
    always @(posedge clk) begin
        if (rdValid === 1'b1) cmp_rd(expQ.size() > 0 ? expQ.pop_front() : 8'hxx, rdData);
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (shadow.exists(a)) shadow[a] = d;
        i_ctrl.op(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        expQ.push_back(sh(a));
        i_ctrl.op(1'b0, 1'b1, a, 8'h00);
    endtask
    task automatic fine(input logic [9:0] fc);
        expQ.push_back(sh(8'h5a));
        shadow[8'h5a] = {sh(8'h5a) & 8'hfc} | {6'h00, fc[9:8]};
        shadow[8'h54] = fc[7:0];
        i_ctrl.set_fine(fc);
    endtask
    task automatic finish_test();
        if (expQ.size() != 0) n_errors++;
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #100us;
        n_errors++;
        finish_test();
    end

    // ==========================================================
    // Scenarios
    initial begin
        logic [5:0] cc;
        arst_n = 1'b0;
        n_errors = 0;
        check_count = 0;
        lfsr = 8'h15;
        foreach (ADDRS[i]) shadow[ADDRS[i]] = 8'h00;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        cmp_trim(exp_trim());
        foreach (ADDRS[i]) rd(ADDRS[i]);
        repeat (6) begin
            lfsr = lfsr_next(lfsr);
            wr(8'h55, {1'b0, lfsr[6:0]});
            cmp_trim(exp_trim());
            rd(8'h55);
        end
        // Ends of the range, then two codes drawn from the LFSR
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(8'h57, (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : {2'b00, lfsr[5:0]});
            cmp_trim(exp_trim());
            rd(8'h57);
        end
        // Last pass uses a code outside the table
        for (int i = 0; i < 8; i++) begin
            cc = (i < 7) ? RANGE_CODE[i] : 6'h2a;
            wr(8'h51, {3'b000, cc[5:1]});
            wr(8'h52, {7'h00, cc[0]});
            cmp_trim(exp_trim());
        end
        wr(8'h5a, 8'h80);
        cmp_trim(exp_trim());
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            fine((i == 0) ? 10'h3ff : (i == 1) ? 10'h000 : {lfsr[1:0], lfsr});
            cmp_trim(exp_trim());
        end
        // Reset in mid-run clears every byte back to zero
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        foreach (ADDRS[i]) shadow[ADDRS[i]] = 8'h00;
        cmp_trim(exp_trim());
        rd(8'h5a);
        rd(8'h53);
        wr(8'h56, 8'h3c);
        cmp_trim(exp_trim());
        // Read and write together: old byte answered, new byte kept
        expQ.push_back(sh(8'h57));
        shadow[8'h57] = 8'h15;
        i_ctrl.op(1'b1, 1'b1, 8'h57, 8'h15);
        rd(8'h57);
        // Write then read on consecutive edges
        lfsr = lfsr_next(lfsr);
        shadow[8'h57] = {2'b00, lfsr[5:0]};
        expQ.push_back(shadow[8'h57]);
        i_ctrl.op_pair('{wr: 1'b1, rd: 1'b0, addr: 8'h57, data: {2'b00, lfsr[5:0]}},
                       '{wr: 1'b0, rd: 1'b1, addr: 8'h57, data: 8'h00});
        cmp_trim(exp_trim());
        repeat (3) @(posedge clk);
        finish_test();
    end
endmodule
